// [core/rivec_core.sv]
// Reset cause flags, interrupt vectoring, return stack and context buffer
`timescale 1ns/100ps
`include "rivec_params.svh"

// How it works
// [RULE_01] Any reset sends fetch to 0000h and restores registers to defaults.
// [RULE_02] Cause flags: power-on 1/0, watchdog 0/0, pin 1/1 (timeout, power-down).
// [RULE_03] Serviced interrupt pushes PC, then fetch continues at 0008h.
// [RULE_04] One shared vector for all sources; software tells them apart.
// [RULE_05] Seven sources: two timers, two timer/counters, comparator, serial, pin.
// [RULE_06] The return-address stack holds eight levels.
// [RULE_07] Save copies accumulator and flags; restore copies back, cause flags untouched.
// [RULE_08] Save buffer is one level deep; a second save overwrites the first.
// [RULE_09] Outside party pulls reset pin low to reset; high otherwise.
// [RULE_10] Reset pin is an input-only port bit only when external reset disabled.
// [RULE_11] Flag register holds cause flags, page and status; lives at 86h.
// [RULE_12] Return from interrupt pops the saved PC and resumes there.
module rivec_core (
  input wire logic clock, // CPU clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic power_on_reset, // Power-on reset event
  input wire logic watchdog_reset, // Watchdog overflow reset event
  input wire logic reset_pin, // Shared reset pin level
  input wire logic ext_reset_enable, // Configuration: pin is external reset
  input wire logic [`RIVEC_NUM_IRQ-1:0] irq_request, // Masked requests from sources
  input wire logic global_irq_enable, // Interrupts allowed by the core
  input wire logic [`RIVEC_PC_W-1:0] current_pc, // PC of the next instruction
  input wire logic return_from_interrupt, // Return instruction executes
  input wire logic context_save, // Save instruction executes
  input wire logic context_restore, // Restore instruction executes
  input wire logic [7:0] accumulator, // Live accumulator value
  input wire logic [7:0] program_flag_register, // Live flag register value
  output logic fetch_redirect, // Load fetch_address this cycle
  output logic [`RIVEC_PC_W-1:0] fetch_address, // Redirected fetch address
  output logic irq_taken, // Interrupt entry pulse
  output logic restore_valid, // Restored values valid pulse
  output logic [7:0] restored_accumulator, // Accumulator from save buffer
  output logic [7:0] restored_flags, // Flags from save buffer, cause kept
  output logic timeout_reset_flag, // Reset cause flag
  output logic power_down_flag, // Reset cause flag
  output logic [7:0] flag_reg_address, // Location of the flag register
  output logic shared_input_only_port_bit, // Pin as plain input
  output logic [3:0] stack_level // Return stack occupancy
);
  import rivec_pkg::*;

  localparam int DEPTH = `RIVEC_STACK_DEPTH;

  // Pin resets only when configured as reset
  logic pin_reset;
  assign pin_reset = ext_reset_enable && !reset_pin; // RULE_09
  assign shared_input_only_port_bit = ext_reset_enable ? 1'b0 : reset_pin; // RULE_10
  assign flag_reg_address = `RIVEC_PROGRAM_FLAG_REGISTER_ADDR; // RULE_11

  logic any_reset;
  assign any_reset = !resetn || power_on_reset || watchdog_reset || pin_reset;

  // Cause priority: power-on beats pin beats watchdog
  function automatic rivec_cause_t cause_of(input logic por, input logic pin);
    if (por) begin
      cause_of = RIVEC_RST_POWER;
    end else if (pin) begin
      cause_of = RIVEC_RST_PIN;
    end else begin
      cause_of = RIVEC_RST_WATCHDOG;
    end
  endfunction : cause_of

  // Cause flags state
  logic next_to;
  logic next_pd;
  always_comb begin
    next_to = timeout_reset_flag;
    next_pd = power_down_flag;
    if (!resetn || power_on_reset || watchdog_reset || pin_reset) begin
      unique case (cause_of(power_on_reset || !resetn, pin_reset))
        RIVEC_RST_POWER: begin
          next_to = 1'b1; // RULE_02
          next_pd = 1'b0;
        end
        RIVEC_RST_WATCHDOG: begin
          next_to = 1'b0; // RULE_02
          next_pd = 1'b0;
        end
        RIVEC_RST_PIN: begin
          next_to = 1'b1; // RULE_02
          next_pd = 1'b1;
        end
        default: begin
          next_to = 1'b1;
          next_pd = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clock) begin
    timeout_reset_flag <= next_to;
    power_down_flag <= next_pd;
  end

  // Return stack: eight entries and a level counter
  logic [`RIVEC_PC_W-1:0] stack_mem [DEPTH];
  logic [`RIVEC_PC_W-1:0] next_stack [DEPTH];
  logic [3:0] next_level;
  logic take_irq;
  logic do_pop;
  // Entry blocked while a full stack would lose a return address
  assign take_irq = |irq_request && global_irq_enable && !any_reset
    && (stack_level != 4'(DEPTH)); // RULE_04 RULE_05
  assign do_pop = return_from_interrupt && !take_irq && !any_reset && (stack_level != 4'h0);

  always_comb begin
    next_stack = stack_mem;
    next_level = stack_level;
    if (any_reset) begin
      next_level = 4'h0; // RULE_01
    end else if (take_irq) begin
      next_stack[stack_level[2:0]] = current_pc; // RULE_03 RULE_06
      next_level = stack_level + 4'h1;
    end else if (do_pop) begin
      next_level = stack_level - 4'h1; // RULE_12
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_stack
      always_ff @(posedge clock) begin
        stack_mem[gi] <= next_stack[gi];
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    stack_level <= next_level;
  end

  // Fetch redirection outputs, registered
  logic next_redirect;
  logic [`RIVEC_PC_W-1:0] next_addr;
  logic [2:0] top_index;
  assign top_index = 3'(stack_level - 4'h1);
  always_comb begin
    next_redirect = 1'b0;
    next_addr = fetch_address;
    if (any_reset) begin
      next_redirect = 1'b1;
      next_addr = `RIVEC_RESET_VECTOR; // RULE_01
    end else if (take_irq) begin
      next_redirect = 1'b1;
      next_addr = `RIVEC_IRQ_VECTOR; // RULE_03 RULE_04
    end else if (do_pop) begin
      next_redirect = 1'b1;
      next_addr = stack_mem[top_index]; // RULE_12
    end
  end
  always_ff @(posedge clock) begin
    fetch_redirect <= next_redirect;
    fetch_address <= next_addr;
    irq_taken <= take_irq;
  end

  // One-level context buffer; save overwrites, restore keeps cause flags
  logic [7:0] save_acc;
  logic [7:0] save_flags;
  logic [7:0] next_save_acc;
  logic [7:0] next_save_flags;
  logic next_rvalid;
  logic [7:0] next_racc;
  logic [7:0] next_rflags;
  always_comb begin
    next_save_acc = save_acc;
    next_save_flags = save_flags;
    next_rvalid = 1'b0;
    next_racc = restored_accumulator;
    next_rflags = restored_flags;
    if (any_reset) begin
      next_save_acc = `RIVEC_ACC_RESET; // RULE_01
      next_save_flags = `RIVEC_PROGRAM_FLAG_REGISTER_RESET;
      next_racc = `RIVEC_ACC_RESET;
      next_rflags = `RIVEC_PROGRAM_FLAG_REGISTER_RESET;
    end else if (context_save) begin
      next_save_acc = accumulator; // RULE_07 RULE_08
      next_save_flags = program_flag_register;
    end else if (context_restore) begin
      next_rvalid = 1'b1;
      next_racc = save_acc; // RULE_07
      next_rflags = save_flags;
      next_rflags[`RIVEC_FLAG_TO_BIT] = timeout_reset_flag; // RULE_07
      next_rflags[`RIVEC_FLAG_PD_BIT] = power_down_flag;
    end
  end
  always_ff @(posedge clock) begin
    save_acc <= next_save_acc;
    save_flags <= next_save_flags;
    restore_valid <= next_rvalid;
    restored_accumulator <= next_racc;
    restored_flags <= next_rflags;
  end

  // Checks
  sequence s_irq_in;
    take_irq;
  endsequence
  sequence s_vector_out;
    fetch_redirect && fetch_address == `RIVEC_IRQ_VECTOR && irq_taken;
  endsequence

  chk_irq_vector: assert property (@(posedge clock) disable iff (!resetn)
    s_irq_in |=> s_vector_out) else $error("interrupt did not vector to 0008h"); // RULE_03
  chk_irq_push: assert property (@(posedge clock) disable iff (!resetn)
    take_irq |=> stack_level == $past(stack_level) + 4'h1) else $error("push missing"); // RULE_06
  chk_stack_bound: assert property (@(posedge clock) disable iff (!resetn)
    stack_level <= 4'(DEPTH)) else $error("stack over eight levels"); // RULE_06
  chk_reset_vector: assert property (@(posedge clock)
    (power_on_reset || watchdog_reset) |=> fetch_redirect && fetch_address == `RIVEC_RESET_VECTOR
    && stack_level == 4'h0) else $error("reset not to 0000h"); // RULE_01
  chk_wdt_cause: assert property (@(posedge clock)
    (watchdog_reset && !power_on_reset && !pin_reset && resetn) |=> !timeout_reset_flag && !power_down_flag)
    else $error("watchdog cause wrong"); // RULE_02
  chk_pin_cause: assert property (@(posedge clock)
    (pin_reset && !power_on_reset && resetn) |=> timeout_reset_flag && power_down_flag)
    else $error("pin cause wrong"); // RULE_02
  chk_pop_return: assert property (@(posedge clock) disable iff (!resetn)
    do_pop |=> fetch_redirect && fetch_address == $past(stack_mem[top_index]))
    else $error("return address wrong"); // RULE_12
  chk_ctx_roundtrip: assert property (@(posedge clock) disable iff (!resetn)
    (context_save && !any_reset) ##1 (context_restore && !context_save && !any_reset)
    |=> restore_valid && restored_accumulator == $past(accumulator, 2)) else $error("context lost"); // RULE_07 RULE_08
  chk_pin_input: assert property (@(posedge clock)
    ext_reset_enable |-> shared_input_only_port_bit == 1'b0) else $error("pin leaks as input"); // RULE_10
endmodule : rivec_core

// [shared/rivec_params.svh]
// Constants for the reset and interrupt vectoring unit
`ifndef RIVEC_PARAMS_SVH
`define RIVEC_PARAMS_SVH
`define RIVEC_PC_W 11
`define RIVEC_RESET_VECTOR 11'h000
`define RIVEC_IRQ_VECTOR 11'h008
`define RIVEC_STACK_DEPTH 8
`define RIVEC_NUM_IRQ 7
`define RIVEC_PROGRAM_FLAG_REGISTER_ADDR 8'h86
`define RIVEC_PROGRAM_FLAG_REGISTER_RESET 8'h00
`define RIVEC_ACC_RESET 8'h00
`define RIVEC_FLAG_TO_BIT 7
`define RIVEC_FLAG_PD_BIT 6
`endif

// [shared/rivec_pkg.sv]
// Types for the reset and interrupt vectoring unit
package rivec_pkg;
  typedef enum logic [1:0] {
    RIVEC_RST_POWER = 2'h0,
    RIVEC_RST_WATCHDOG = 2'h1,
    RIVEC_RST_PIN = 2'h2
  } rivec_cause_t;
endpackage : rivec_pkg

// [tb/rivec_src.sv]
// Interrupt sources and reset pin model
`timescale 1ns/100ps
module rivec_src (
  input wire logic clock, // CPU clock
  input wire logic resetn, // Reset, active low
  input wire logic [6:0] ev, // Source events
  input wire logic withdraw, // Software clears flags
  input wire logic pin_req, // Ask for pin reset
  input wire logic irq_taken, // Entry seen
  output logic [6:0] irq_request, // Pending requests
  output logic reset_pin // Pin level
);
  logic [6:0] pending;
  // Flags hold until entry or software clears them
  always_ff @(posedge clock) begin
    if (!resetn || withdraw || irq_taken) begin
      pending <= 7'h00;
    end else begin
      pending <= pending | ev;
    end
  end
  // Masked during entry so one event gives one entry
  assign irq_request = pending & ~{7{irq_taken}};
  // Pull-up keeps the pin high when idle
  assign reset_pin = ~pin_req;
endmodule : rivec_src

// [tb/reset_interrupt_vectoring_tb.sv]
// Bench for the reset and interrupt vectoring unit
`timescale 1ns/100ps
`include "rivec_params.svh"
module reset_interrupt_vectoring_tb;
  logic clock = 0, resetn = 0, por = 0, wdr = 0, ext_en = 1, gie = 1, rti = 0, sv = 0, rs = 0, wd = 0, preq = 0;
  logic [6:0] ev = 7'h00, irq;
  logic [10:0] pc = 11'h000, fa;
  logic [7:0] acc = 8'h00, pfl = 8'h00, racc, rfl, fra;
  logic rpin, fr, it, rv, to, pd, pbit, mon = 0;
  logic [3:0] lvl;
  logic [15:0] eq[$];
  logic [15:0] seen;
  logic [10:0] ps[$];
  integer seed = 55, failures = 0, check_count = 0, i;
  initial forever #2.5 clock = ~clock;
  rivec_src src (.clock(clock), .resetn(resetn), .ev(ev), .withdraw(wd), .pin_req(preq), .irq_taken(it),
    .irq_request(irq), .reset_pin(rpin));
  rivec_core DUT (.clock(clock), .resetn(resetn), .power_on_reset(por), .watchdog_reset(wdr), .reset_pin(rpin),
    .ext_reset_enable(ext_en), .irq_request(irq), .global_irq_enable(gie), .current_pc(pc),
    .return_from_interrupt(rti), .context_save(sv), .context_restore(rs), .accumulator(acc),
    .program_flag_register(pfl), .fetch_redirect(fr), .fetch_address(fa), .irq_taken(it), .restore_valid(rv),
    .restored_accumulator(racc), .restored_flags(rfl), .timeout_reset_flag(to), .power_down_flag(pd),
    .flag_reg_address(fra), .shared_input_only_port_bit(pbit), .stack_level(lvl));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // Raise one source; the pushed PC is kept for the matching return
  task automatic irq_one(input int s);
    pc = 11'($random(seed));
    eq.push_back({4'h0, 1'b1, `RIVEC_IRQ_VECTOR});
    ps.push_back(pc);
    ev = 7'h01 << s;
    cyc(1);
    ev = 7'h00;
    cyc(3);
    chk("stack level", 16'(ps.size()), {12'h000, lvl});
  endtask : irq_one
  task automatic rst(input int k, input logic [1:0] fl);
    por = (k == 0);
    wdr = (k == 1);
    preq = (k == 2);
    cyc(1);
    por = 0;
    wdr = 0;
    preq = 0;
    chk("reset entry", {1'b1, `RIVEC_RESET_VECTOR, 4'h0}, {fr, fa, lvl});
    chk("cause flags", {14'h0, fl}, {14'h0, to, pd});
    // Idle edge so back-to-back resets never retoggle a line in one step
    cyc(1);
  endtask : rst
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // Each entry, return or restore takes the oldest note
  always @(negedge clock) begin
    seen = (fr === 1'b1) ? {4'h0, it, fa} : {racc, rfl};
    if (mon && (fr === 1'b1 || rv === 1'b1)) begin
      if (eq.size() == 0) begin
        failures++;
        $display("CHECK FAILED unexpected event expected none seen %h", seen);
      end else begin
        chk("entry or restore", eq.pop_front(), seen);
      end
    end
  end
  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    end_of_test();
  end
  initial begin
    cyc(2);
    resetn = 1;
    chk("power-on flags", 16'h0002, {14'h0, to, pd});
    chk("flag reg place", {8'h00, `RIVEC_PROGRAM_FLAG_REGISTER_ADDR}, {8'h00, fra});
    // Let the reset redirect pass before the monitor starts listening
    cyc(1);
    mon = 1;
    for (i = 0; i < 8; i++) irq_one(i % 7);
    // Full stack must refuse a ninth entry
    ev = 7'h40;
    cyc(1);
    ev = 7'h00;
    cyc(3);
    chk("full stack", 16'h0008, {12'h000, lvl});
    wd = 1;
    cyc(1);
    wd = 0;
    for (i = 0; i < 8; i++) begin
      eq.push_back({5'h00, ps.pop_back()});
      rti = 1;
      cyc(1);
      rti = 0;
      cyc(2);
    end
    rti = 1;
    cyc(1);
    rti = 0;
    cyc(2);
    chk("empty pop", 16'h0000, {12'h000, lvl});
    $display("test vectoring done");
    // Pin as plain input while external reset is off
    ext_en = 0;
    preq = 1;
    cyc(2);
    chk("port bit low", 16'h0000, {15'h0, pbit});
    preq = 0;
    cyc(1);
    chk("port bit high", 16'h0001, {15'h0, pbit});
    ext_en = 1;
    // Entry held off while the core disallows interrupts
    gie = 0;
    ev = 7'h04;
    cyc(1);
    ev = 7'h00;
    cyc(3);
    chk("gated entry", 16'h0000, {12'h000, lvl});
    gie = 1;
    irq_one(2);
    mon = 0;
    rst(1, 2'b00);
    rst(0, 2'b10);
    rst(2, 2'b11);
    $display("test resets done");
    cyc(1);
    mon = 1;
    for (i = 0; i < 2; i++) begin
      acc = 8'($random(seed));
      pfl = 8'($random(seed));
      sv = 1;
      cyc(1);
    end
    sv = 0;
    rs = 1;
    eq.push_back({acc, 2'b11, pfl[5:0]});
    cyc(1);
    rs = 0;
    acc = 8'h00;
    cyc(3);
    chk("notes left", 16'h0000, 16'(eq.size()));
    $display("test context done");
    end_of_test();
  end
endmodule : reset_interrupt_vectoring_tb
